/* rtl/wake_signal_strength_pin_map.vh */
// Constants for the wake generator and pin output selection.
// Assumes inclusion by bare name from rtl/ sources.
`ifndef WAKE_SIGNAL_STRENGTH_PIN_MAP_VH
`define WAKE_SIGNAL_STRENGTH_PIN_MAP_VH
// Artificial wake period in seconds, 2h 16min 32sec
`define WAKE_PERIOD_SEC 8192
// Low-frequency tick rate in Hz
`define LF_TICK_HZ 32768
// System clock rate in Hz
`define REF_CLK_HZ 250000000
// Oscillator ticks per artificial wake period
`define WAKE_PERIOD_TICKS (`WAKE_PERIOD_SEC * `LF_TICK_HZ)
// Width of the wake overflow counter
`define WAKE_CNT_W 28
// Width of the tick prescaler
`define TICK_DIV_W 13
// Clock cycles per oscillator tick (rounded down)
`define TICK_DIV_CYCLES (`REF_CLK_HZ / `LF_TICK_HZ)
// Last count of the wake period counter, sized for it
`define WAKE_PERIOD_LAST 28'hFFFFFFF
// Last count of the tick prescaler, sized for it
`define TICK_DIV_LAST 13'h1DCC
// Channel select codes
`define CHAN_ONE 2'h0
`define CHAN_TWO 2'h1
`define CHAN_THREE 2'h2
`define CHAN_RESERVED 2'h3
// Test select codes {high,low}
`define TEST_SEL_DATA 2'h0
`define TEST_SEL_WAKE 2'h1
// Strength pin digital mode {high,low}
`define STRENGTH_MODE_DIGITAL 2'h2
// Zero half-bit tolerance limit
`define ZERO_TOL_MAX 2'h2
`endif

/* rtl/wake_period_counter.v */
// Free-running overflow counter raising a one-cycle artificial wake pulse.
// Assumes a clock enable and a tick strobe from the parent.
`default_nettype none
module wake_period_counter #(
   parameter CNT_W = 28,
   parameter [CNT_W-1:0] PERIOD_TICKS = 28'hFFFFFFF
) (
   input wire ref_clk_in,
   input wire reset_n_in,
   input wire clk_en_in,
   input wire tick_in,
   input wire run_in,
   output reg overflow_out
);
   reg [CNT_W-1:0] count;
   wire at_end = (count == PERIOD_TICKS);
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count <= {CNT_W{1'b0}};
         overflow_out <= 1'b0;
      end else if (clk_en_in) begin
         overflow_out <= 1'b0;
         // Never cleared by wake clearing; only counts while enabled
         if (tick_in && run_in) begin
            if (at_end) begin
               count <= {CNT_W{1'b0}};
               overflow_out <= 1'b1;
            end else begin
               count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // wake_period_counter
`default_nettype wire

/* rtl/wake_signal_strength_pin_output_select.v */
// Wake generator, wake pin test routing and strength pin digital output.
// Assumes synchronous pin inputs and control bits held by the controller.
// Summary of operation
// - Counter overflow raises artificial wakeup each period
// - Generator runs only while enable bit set
// - First wake undefined, later ones periodic
// - Overflow counter never reset by clearing
// - Test data routing puts channel data out
// - Channel select picks channel one to three
// - Test disabled gives combined wake on the wake pin
// - Test wake routing gives single channel wake
// - Both channel bits give combined wake
// - Strength pin driven only with chip select
// - Zero half-bit tolerance selectable zero to two
// - Tau bit selects large or small filter
// - Normal wake is OR of channels and artificial wake
// - Tau bit zero small, one large
`include "wake_signal_strength_pin_map.vh"
`default_nettype none
module wake_signal_strength_pin_output_select #(
   parameter CNT_W = `WAKE_CNT_W,
   parameter [CNT_W-1:0] PERIOD_TICKS = `WAKE_PERIOD_LAST,
   parameter DIV_W = `TICK_DIV_W,
   parameter [DIV_W-1:0] TICK_DIV = `TICK_DIV_LAST
) (
   input wire ref_clk_in,
   input wire reset_n_in,
   input wire clk_en_in,
   input wire [2:0] channel_data_in,
   input wire [2:0] channel_wake_in,
   input wire wake_clear_in,
   input wire test_route_enable_in,
   input wire test_select_low_in,
   input wire test_select_high_in,
   input wire artificial_wake_enable_in,
   input wire channel_select_low_in,
   input wire channel_select_high_in,
   input wire strength_out_mode_low_in,
   input wire strength_out_mode_high_in,
   input wire chip_select_in,
   input wire [1:0] zero_tolerance_in,
   input wire threshold_tau_select_in,
   output reg wake_pin_out,
   output reg signal_strength_pin_out,
   output reg signal_strength_pin_oe_out,
   output reg artificial_wake_out,
   output reg [1:0] zero_tolerance_out,
   output reg large_tau_out
);
   reg [DIV_W-1:0] tick_div;
   reg [DIV_W-1:0] next_tick_div;
   reg tick;
   reg next_tick;
   reg art_pending;
   reg next_art_pending;
   reg routed;
   reg next_strength;
   reg [1:0] next_zero_tolerance;
   wire overflow;
   wire [2:0] wake_src;
   wire combined_wake;
   wire [1:0] chan_sel;
   wire [1:0] test_sel;
   wire [1:0] mode_sel;
   wire next_wake_pin;
   wire strength_digital;

   // Picks the channel bit; reserved code yields the fallback
   function pick;
      input [2:0] bits;
      input [1:0] sel;
      input fallback;
      begin
         case (sel)
            `CHAN_ONE: pick = bits[0];
            `CHAN_TWO: pick = bits[1];
            `CHAN_THREE: pick = bits[2];
            default: pick = fallback;
         endcase
      end
   endfunction

   // Oscillator tick prescaler; wraps after TICK_DIV + 1 cycles
   // Rounding the ratio down makes the wake period run slightly short
   always @* begin
      next_tick = 1'b0;
      next_tick_div = tick_div + {{(DIV_W-1){1'b0}}, 1'b1};
      if (tick_div == TICK_DIV) begin
         next_tick = 1'b1;
         next_tick_div = {DIV_W{1'b0}};
      end
   end

   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tick_div <= {DIV_W{1'b0}};
         tick <= 1'b0;
      end else if (clk_en_in) begin
         tick_div <= next_tick_div;
         tick <= next_tick;
      end
   end

   // Count survives disable and wake clearing, so the first wake after
   // enable lands at an undefined point of the period

   wake_period_counter #(
      .CNT_W(CNT_W),
      .PERIOD_TICKS(PERIOD_TICKS)
   ) u_counter (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .clk_en_in(clk_en_in),
      .tick_in(tick),
      .run_in(artificial_wake_enable_in),
      .overflow_out(overflow)
   );

   // Artificial wake held until cleared; overflow wins over clear
   always @* begin
      next_art_pending = art_pending;
      if (overflow) begin
         next_art_pending = 1'b1;
      end else if (wake_clear_in) begin
         next_art_pending = 1'b0;
      end
   end

   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         art_pending <= 1'b0;
      end else if (clk_en_in) begin
         art_pending <= next_art_pending;
      end
   end

   // Channel wakes are cleared at their source; only the latch clears here
   assign wake_src = channel_wake_in;
   assign combined_wake = (|wake_src) | art_pending;
   assign chan_sel = {channel_select_high_in, channel_select_low_in};
   assign test_sel = {test_select_high_in, test_select_low_in};
   assign mode_sel = {strength_out_mode_high_in, strength_out_mode_low_in};

   // Single channel choice by select bits
   always @* begin
      case (test_sel)
         `TEST_SEL_DATA: begin
            routed = pick(channel_data_in, chan_sel, combined_wake);
         end
         `TEST_SEL_WAKE: begin
            routed = pick(wake_src, chan_sel, combined_wake);
         end
         default: begin
            // Undefined test selects fall back to the combined wake
            routed = combined_wake;
         end
      endcase
   end
   // Data routing wake routing normal
   assign next_wake_pin = test_route_enable_in ? routed : combined_wake;

   assign strength_digital = (mode_sel == `STRENGTH_MODE_DIGITAL);
   // Combined wake on reserved code regardless of test bits
   always @* begin
      if (chan_sel == `CHAN_RESERVED) begin
         next_strength = combined_wake;
      end else begin
         next_strength = routed;
      end
   end

   // Requests above the supported limit read back as the limit
   always @* begin
      if (zero_tolerance_in > `ZERO_TOL_MAX) begin
         next_zero_tolerance = `ZERO_TOL_MAX;
      end else begin
         next_zero_tolerance = zero_tolerance_in;
      end
   end

   // Wake pin register
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wake_pin_out <= 1'b0;
      end else if (clk_en_in) begin
         wake_pin_out <= next_wake_pin;
      end
   end

   // Strength pin value is low whenever the pin is released
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         signal_strength_pin_out <= 1'b0;
         signal_strength_pin_oe_out <= 1'b0;
      end else if (clk_en_in) begin
         signal_strength_pin_out <= strength_digital & chip_select_in & next_strength;
         signal_strength_pin_oe_out <= strength_digital & chip_select_in;
      end
   end

   // Controller-visible copy of the artificial wake latch
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         artificial_wake_out <= 1'b0;
      end else if (clk_en_in) begin
         artificial_wake_out <= art_pending;
      end
   end

   // Correlator settings; large tau out of reset
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         zero_tolerance_out <= 2'h0;
         large_tau_out <= 1'b1;
      end else if (clk_en_in) begin
         zero_tolerance_out <= next_zero_tolerance;
         large_tau_out <= threshold_tau_select_in;
      end
   end
endmodule // wake_signal_strength_pin_output_select
`default_nettype wire

/* verification/wake_signal_strength_pin_output_select_properties.sv */
// Port assertions for the wake and strength pin selector.
// Assumes binding to that module, ports matched by name.
`default_nettype none
module wake_signal_strength_pin_checker (
   input wire logic ref_clk_in, reset_n_in, clk_en_in, wake_clear_in, chip_select_in,
   input wire logic [2:0] channel_data_in, channel_wake_in,
   input wire logic test_route_enable_in, test_select_low_in, test_select_high_in,
   input wire logic channel_select_low_in, channel_select_high_in, threshold_tau_select_in,
   input wire logic strength_out_mode_low_in, strength_out_mode_high_in,
   input wire logic [1:0] zero_tolerance_in, zero_tolerance_out,
   input wire logic wake_pin_out, signal_strength_pin_out, signal_strength_pin_oe_out,
   input wire logic artificial_wake_out, large_tau_out
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [1:0] cs = {channel_select_high_in, channel_select_low_in};
   wire [1:0] ts = {test_select_high_in, test_select_low_in};
   wire te = clk_en_in && test_route_enable_in;
   wire aw = artificial_wake_out;
   wire dig = chip_select_in && strength_out_mode_high_in && !strength_out_mode_low_in;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   norm_wake_a: assert property (clk_en_in && !test_route_enable_in && !aw |=>
      aw || wake_pin_out == |$past(channel_wake_in)) else $error("wake pin not combined");
   route_data_a: assert property (te && ts == 2'h0 && cs != 2'h3 |=>
      wake_pin_out == $past(channel_data_in[cs])) else $error("data route wrong");
   route_wake_a: assert property (te && ts == 2'h1 && cs != 2'h3 |=>
      wake_pin_out == $past(channel_wake_in[cs])) else $error("wake route wrong");
   reserved_chan_a: assert property (te && cs == 2'h3 && !aw |=>
      aw || wake_pin_out == |$past(channel_wake_in)) else $error("reserved code wrong");
   strength_oe_a: assert property (clk_en_in |=>
      signal_strength_pin_oe_out == $past(dig)) else $error("strength enable wrong");
   strength_idle_a: assert property (!signal_strength_pin_oe_out |->
      !signal_strength_pin_out) else $error("strength driven while off");
   tol_clamp_a: assert property (clk_en_in |=> zero_tolerance_out ==
      ($past(zero_tolerance_in) == 2'h3 ? 2'h2 : $past(zero_tolerance_in))) else $error("tol");
   tau_copy_a: assert property (clk_en_in |=>
      large_tau_out == $past(threshold_tau_select_in)) else $error("tau copy wrong");
   wake_hold_a: assert property (clk_en_in && aw && !wake_clear_in &&
      !$past(wake_clear_in) |=> aw) else $error("artificial wake lost");
endmodule // wake_signal_strength_pin_checker
bind wake_signal_strength_pin_output_select wake_signal_strength_pin_checker chk_i (.*);
`default_nettype wire

/* verification/wake_controller_model.sv */
// Controlling unit model: clears a wake that no channel claims.
// Assumes channel wakes are cleared by the bench.
`default_nettype none
module wake_controller_model (
   input wire logic clk_in,
   input wire logic wake_in,
   input wire logic [2:0] chan_wake_in,
   output logic clear_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic seen = 1'h0;
   initial clear_out = 1'h0;
   // Clears one cycle after an unclaimed wake, as a polling controller would
   always @(negedge clk_in) begin
      seen <= wake_in && chan_wake_in == 3'h0;
      clear_out <= seen && wake_in && chan_wake_in == 3'h0;
   end
endmodule // wake_controller_model
`default_nettype wire

/* verification/wake_signal_strength_pin_output_select_tb.sv */
// Self-checking bench for the wake and strength pin selector.
// Assumes short wake period parameters and the controller model.
`default_nettype none
module wake_signal_strength_pin_output_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_in = 1'h0, reset_n_in = 1'h0, clk_en_in = 1'h1, wake_clear_in;
   logic test_route_enable_in, test_select_low_in, test_select_high_in, chip_select_in;
   logic channel_select_low_in, channel_select_high_in, threshold_tau_select_in = 1'h0;
   logic strength_out_mode_low_in, strength_out_mode_high_in, artificial_wake_enable_in = 1'h0;
   logic [2:0] channel_data_in = 3'h0, channel_wake_in = 3'h0;
   logic [1:0] zero_tolerance_in = 2'h0, zero_tolerance_out;
   logic wake_pin_out, signal_strength_pin_out, signal_strength_pin_oe_out;
   logic artificial_wake_out, large_tau_out, r;
   int bad_count = 0, samples_checked = 0, n;
   wake_signal_strength_pin_output_select #(.PERIOD_TICKS(28'h7), .TICK_DIV(13'h1)) dut (.*);
   wake_controller_model ctl (.clk_in(ref_clk_in), .wake_in(artificial_wake_out),
      .chan_wake_in(channel_wake_in), .clear_out(wake_clear_in));
   initial forever #2 ref_clk_in = ~ref_clk_in;
   task tally_and_finish;
      $display("checks %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [1:0] s, input logic [1:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, s, e);
      end
   endtask
   // Fields: route enable, test sel, channel sel, strength mode, chip select
   task cfg(input logic [7:0] v);
      {test_route_enable_in, test_select_high_in, test_select_low_in, channel_select_high_in,
         channel_select_low_in, strength_out_mode_high_in, strength_out_mode_low_in,
         chip_select_in} = v;
   endtask
   task t_route;
      for (int p = 0; p < 2; p++) for (int i = 0; i < 3; i++) for (int j = 0; j < 2; j++) begin
         cfg({p[0], 1'h0, j[0], i[1:0], 3'h5});
         channel_data_in = p[0] ? ~(3'h1 << i) : 3'h1 << i;
         channel_wake_in = ~channel_data_in;
         r = j[0] ? channel_wake_in[i] : channel_data_in[i];
         @(negedge ref_clk_in);
         chk(wake_pin_out, p[0] ? r : |channel_wake_in);
         chk(signal_strength_pin_out, r);
      end
   endtask
   task t_cs;
      channel_data_in = 3'h0;
      channel_wake_in = 3'h2;
      cfg(8'h9D);
      @(negedge ref_clk_in);
      chk(wake_pin_out, 1'h1);
      chk({signal_strength_pin_oe_out, signal_strength_pin_out}, 2'h3);
      cfg(8'h9C);
      @(negedge ref_clk_in);
      chk({signal_strength_pin_oe_out, signal_strength_pin_out}, 2'h0);
      cfg(8'h9F);
      @(negedge ref_clk_in);
      chk(signal_strength_pin_oe_out, 1'h0);
      channel_wake_in = 3'h4;
      cfg(8'hCD);
      @(negedge ref_clk_in);
      chk(wake_pin_out, 1'h1);
      chk({signal_strength_pin_oe_out, signal_strength_pin_out}, 2'h3);
   endtask
   task t_misc;
      for (int k = 0; k < 4; k++) begin
         zero_tolerance_in = k[1:0];
         threshold_tau_select_in = k[0];
         @(negedge ref_clk_in);
         chk(zero_tolerance_out, k == 3 ? 2'h2 : k[1:0]);
         chk(large_tau_out, k[0]);
      end
   endtask
   task t_art;
      cfg(8'h00);
      channel_wake_in = 3'h0;
      repeat (40) @(negedge ref_clk_in);
      chk(artificial_wake_out, 1'h0);
      artificial_wake_enable_in = 1'h1;
      n = 0;
      while (artificial_wake_out !== 1'h1 && n < 100) begin @(negedge ref_clk_in); n++; end
      chk(n < 20, 1'h1);
      n = 0;
      while (artificial_wake_out === 1'h1 && n < 100) begin @(negedge ref_clk_in); n++; end
      while (artificial_wake_out !== 1'h1 && n < 100) begin @(negedge ref_clk_in); n++; end
      chk(n == 16, 1'h1);
   endtask
   initial begin
      cfg(8'h00);
      repeat (3) @(negedge ref_clk_in);
      chk({large_tau_out, artificial_wake_out}, 2'h2);
      reset_n_in = 1'h1;
      t_route;
      t_cs;
      t_misc;
      t_art;
      tally_and_finish;
   end
   initial begin
      #5000;
      bad_count++;
      tally_and_finish;
   end
endmodule // wake_signal_strength_pin_output_select_tb
`default_nettype wire
